/* twc_map.svh */
/*
 * Register offsets, field positions, reset values and fixed counts of the
 * timer waveform control block.
 * Assumes it is included by bare name wherever these names are needed.
 */
`ifndef TWC_MAP_SVH
`define TWC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TWC_OFF_CTRL 2'h0
`define TWC_OFF_COUNT 2'h1
`define TWC_OFF_COMPARE 2'h2
`define TWC_OFF_FLAGS 2'h3

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TWC_BIT_FORCE 7
`define TWC_BIT_WAVE_LOW 6
`define TWC_BIT_OUT_HIGH 5
`define TWC_BIT_OUT_LOW 4
`define TWC_BIT_WAVE_HIGH 3
`define TWC_CS_MSB 2

// ----------------------------------------------------------------------
// Flag register fields
// ----------------------------------------------------------------------
`define TWC_BIT_OVF 0
`define TWC_BIT_CMPF 1

// ----------------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------------
`define TWC_RST_CTRL 8'h00
`define TWC_RST_BYTE 8'h00
`define TWC_MAX 8'hff
`define TWC_PRE_W 10
`define TWC_PC_PERIOD 510

`endif

/* twc_pkg.sv */
/*
 * Types of the timer waveform control block.
 * Assumes twc_map.svh sits beside it.
 */
`include "twc_map.svh"

package twc_pkg;

   typedef enum logic [1:0] {
      TWC_NORMAL = 2'b00,
      TWC_PHASE = 2'b01,
      TWC_CTC = 2'b10,
      TWC_FAST = 2'b11
   } twc_wave_e;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } twc_bus_s;

   typedef struct packed {
      logic out;
      logic oe;
   } twc_pin_s;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] cnt;
      logic [7:0] cmp_buf;
      logic [7:0] cmp_act;
      logic down;
      logic block;
      logic oc;
      logic ovf;
      logic cmpf;
      logic [`TWC_PRE_W-1:0] psc;
      logic [7:0] rdata;
      twc_pin_s pin;
   } twc_state_s;

endpackage

/* twc_timer_waveform_control.sv */
/*
 * 8-bit timer/counter with one compare channel: counting modes, waveform
 * generation, force-compare strobe and pin routing, with register port.
 * Assumes a register master on a plain strobe port, synchronous inputs,
 * and a port data/direction pair from the surrounding I/O port.
 */
// Operation
// - Mode 1 counts up then down repeatedly
// - Phase mode: clear on up, set on down
// - Counter holds 0xFF one tick, then down
// - Phase mode: overflow flag set at bottom
// - Phase mode output: 2 normal, 3 inverted
// - Compare zero/max gives constant low/high
// - At max, output takes up-match result, down-match if compare is max
// - Missed up-match still applied at top
// - Phase period is 510 ticks
// - Prescale 1,8,32,64,128,256,1024
// - Tick is an enable on the clock
// - Force strobe applies compare action immediately, in the non-PWM modes only
// - Force: no flag, no clear, reads zero
// - Mode bits at 3 and 6, codes
// - Compare load and overflow point per mode
// - Output mode nonzero routes compare to pin
// - Non-PWM: off, toggle, clear, set
// - Fast PWM: clear/set match, opposite bottom
// - Compare at top: act at top instead
// - Output mode change acts at match
// - Clock select zero stops the counter

`timescale 1ns/1ns
`include "twc_map.svh"

module twc_timer_waveform_control
   import twc_pkg::*;
#(
   parameter int PRE_W = `TWC_PRE_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input twc_bus_s bus,
   output logic [7:0] rdata,
   // I/O port function sharing the pin
   input wire logic port_data,
   input wire logic port_dir,
   // Pin and flags
   output twc_pin_s pin,
   output logic overflow_flag,
   output logic compare_flag
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Match action: 1 toggle, 2 clear, 3 set, 0 keep
   function automatic logic twc_act(input logic [1:0] com, input logic oc);
      logic r;
      r = oc;
      case (com)
         2'b01: r = ~oc;
         2'b10: r = 1'b0;
         2'b11: r = 1'b1;
         default: r = oc;
      endcase
      return r;
   endfunction

   // Timer tick from the free-running prescaler
   function automatic logic twc_tick(input logic [2:0] cs,
                                     input logic [PRE_W-1:0] p);
      logic t;
      t = 1'b0;
      case (cs)
         3'h1: t = 1'b1;
         3'h2: t = &p[2:0];
         3'h3: t = &p[4:0];
         3'h4: t = &p[5:0];
         3'h5: t = &p[6:0];
         3'h6: t = &p[7:0];
         3'h7: t = &p[9:0];
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   twc_state_s st_reg;
   twc_state_s st_next;
   twc_wave_e wave;
   logic [1:0] com;
   logic tick;
   logic match;
   logic wr_ctrl;
   logic wr_cnt;
   logic wr_cmp;
   logic wr_flags;
   logic force_hit;

   assign wave = twc_wave_e'({st_reg.ctrl[`TWC_BIT_WAVE_HIGH],
                              st_reg.ctrl[`TWC_BIT_WAVE_LOW]});
   assign com = st_reg.ctrl[`TWC_BIT_OUT_HIGH:`TWC_BIT_OUT_LOW];
   assign tick = twc_tick(st_reg.ctrl[`TWC_CS_MSB:0], st_reg.psc);
   assign match = (st_reg.cnt == st_reg.cmp_act) && !st_reg.block;
   assign wr_ctrl = bus.wr && (bus.addr == `TWC_OFF_CTRL);
   assign wr_cnt = bus.wr && (bus.addr == `TWC_OFF_COUNT);
   assign wr_cmp = bus.wr && (bus.addr == `TWC_OFF_COMPARE);
   assign wr_flags = bus.wr && (bus.addr == `TWC_OFF_FLAGS);
   // Strobe only honoured in the non-PWM modes being written
   assign force_hit = wr_ctrl && bus.wdata[`TWC_BIT_FORCE]
                      && !bus.wdata[`TWC_BIT_WAVE_LOW];

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.psc = st_reg.psc + 1'b1;
      if (wr_flags) begin
         st_next.ovf = st_reg.ovf & ~bus.wdata[`TWC_BIT_OVF];
         st_next.cmpf = st_reg.cmpf & ~bus.wdata[`TWC_BIT_CMPF];
      end
      if (wave == TWC_NORMAL || wave == TWC_CTC) begin
         st_next.cmp_act = st_reg.cmp_buf;
      end
      // Counter only advances on enabled clock edges
      if (tick) begin
         st_next.block = 1'b0;
         if (match) begin
            st_next.cmpf = 1'b1;
         end
         case (wave)
            TWC_NORMAL: begin
               st_next.cnt = st_reg.cnt + 8'h01;
               if (st_reg.cnt == `TWC_MAX) begin
                  st_next.ovf = 1'b1;
               end
               if (match) begin
                  st_next.oc = twc_act(com, st_reg.oc);
               end
            end
            TWC_CTC: begin
               if (match) begin
                  st_next.cnt = 8'h00;
                  st_next.oc = twc_act(com, st_reg.oc);
               end else begin
                  st_next.cnt = st_reg.cnt + 8'h01;
                  if (st_reg.cnt == `TWC_MAX) begin
                     st_next.ovf = 1'b1;
                  end
               end
            end
            TWC_FAST: begin
               st_next.cnt = st_reg.cnt + 8'h01;
               if (st_reg.cnt == `TWC_MAX) begin
                  st_next.ovf = 1'b1;
                  st_next.cmp_act = st_reg.cmp_buf;
                  if (com[1] && st_reg.cmp_act == `TWC_MAX) begin
                     st_next.oc = twc_act(com, st_reg.oc);
                  end else if (com[1]) begin
                     st_next.oc = twc_act(com ^ 2'b01, st_reg.oc);
                  end else if (match) begin
                     st_next.oc = twc_act(com, st_reg.oc);
                  end
               end else if (match) begin
                  st_next.oc = twc_act(com, st_reg.oc);
               end
            end
            TWC_PHASE: begin
               if (!st_reg.down) begin
                  if (st_reg.cnt == `TWC_MAX) begin
                     st_next.down = 1'b1;
                     st_next.cnt = st_reg.cnt - 8'h01;
                     st_next.cmp_act = st_reg.cmp_buf;
                     if (com[1] && st_reg.cmp_buf == `TWC_MAX) begin
                        st_next.oc = twc_act(com ^ 2'b01, st_reg.oc);
                     end else if (com[1]) begin
                        st_next.oc = twc_act(com, st_reg.oc);
                     end
                  end else begin
                     st_next.cnt = st_reg.cnt + 8'h01;
                     if (match && com[1]) begin
                        st_next.oc = twc_act(com, st_reg.oc);
                     end
                  end
               end else begin
                  if (st_reg.cnt == 8'h00) begin
                     st_next.down = 1'b0;
                     st_next.cnt = 8'h01;
                     // Bottom counts as up slope: compare zero stays low
                     if (match && com[1]) begin
                        st_next.oc = twc_act(com, st_reg.oc);
                     end
                  end else begin
                     st_next.cnt = st_reg.cnt - 8'h01;
                     if (st_reg.cnt == 8'h01) begin
                        st_next.ovf = 1'b1;
                     end
                     if (match && com[1]) begin
                        st_next.oc = twc_act(com ^ 2'b01, st_reg.oc);
                     end
                  end
               end
            end
            default: st_next.cnt = st_reg.cnt;
         endcase
      end
      // Control, count and compare writes win over counting; a flag set by counting wins over a flag clear
      if (wr_ctrl) begin
         st_next.ctrl = {1'b0, bus.wdata[6:0]};
         if (bus.wdata[`TWC_BIT_WAVE_LOW]) begin
            st_next.cmp_act = st_reg.cmp_act;
         end else begin
            st_next.down = 1'b0;
         end
      end
      if (force_hit) begin
         st_next.oc = twc_act(bus.wdata[`TWC_BIT_OUT_HIGH:`TWC_BIT_OUT_LOW],
                              st_reg.oc);
      end
      if (wr_cnt) begin
         st_next.cnt = bus.wdata;
         st_next.block = 1'b1;
      end
      if (wr_cmp) begin
         st_next.cmp_buf = bus.wdata;
      end
      st_next.rdata = `TWC_RST_BYTE;
      if (bus.rd) begin
         case (bus.addr)
            `TWC_OFF_CTRL: st_next.rdata = {1'b0, st_reg.ctrl[6:0]};
            `TWC_OFF_COUNT: st_next.rdata = st_reg.cnt;
            `TWC_OFF_COMPARE: st_next.rdata = st_reg.cmp_buf;
            `TWC_OFF_FLAGS: st_next.rdata = {6'h00, st_reg.cmpf, st_reg.ovf};
            default: st_next.rdata = `TWC_RST_BYTE;
         endcase
      end
      // Pin takes the compare output whenever the output mode is nonzero
      st_next.pin.out = (st_next.ctrl[`TWC_BIT_OUT_HIGH:`TWC_BIT_OUT_LOW] != 2'b00)
                        ? st_next.oc : port_data;
      st_next.pin.oe = port_dir;
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
         st_reg.ctrl <= `TWC_RST_CTRL;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata = st_reg.rdata;
   assign pin = st_reg.pin;
   assign overflow_flag = st_reg.ovf;
   assign compare_flag = st_reg.cmpf;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic quiet;
   assign quiet = !bus.wr;

   sequence s_pc_top;
      tick && wave == TWC_PHASE && !st_reg.down && st_reg.cnt == `TWC_MAX && quiet;
   endsequence

   sequence s_pc_last_down;
      tick && wave == TWC_PHASE && st_reg.down && st_reg.cnt == 8'h01 && quiet;
   endsequence

   a_pc_top_turn: assert property (s_pc_top |=> st_reg.down && st_reg.cnt == 8'hfe)
      else $error("phase mode did not turn down after one tick at max");

   a_pc_bottom_flag: assert property (s_pc_last_down |=> overflow_flag
                                      && st_reg.cnt == 8'h00)
      else $error("overflow flag not set on reaching bottom");

   a_pc_bottom_turn: assert property (s_pc_last_down ##1 (tick && quiet)
                                      |=> !st_reg.down && st_reg.cnt == 8'h01)
      else $error("phase mode did not turn up after bottom");

   a_clock_stopped: assert property (st_reg.ctrl[2:0] == 3'h0 && quiet
                                     |=> $stable(st_reg.cnt))
      else $error("counter moved with no clock selected");

   a_force_no_flag: assert property (force_hit && !tick && !wr_cnt
                                     |=> $stable(compare_flag) && $stable(st_reg.cnt))
      else $error("force strobe disturbed flag or counter");

   a_force_clear: assert property (force_hit && bus.wdata[5:4] == 2'b10
                                   |=> !st_reg.oc)
      else $error("forced clear did not clear the output");

   a_strobe_zero: assert property (bus.rd && bus.addr == `TWC_OFF_CTRL
                                   |=> !rdata[`TWC_BIT_FORCE])
      else $error("force strobe read back as one");

   a_pin_route: assert property (com != 2'b00 |-> pin.out == st_reg.oc)
      else $error("compare output not routed to pin");

   a_port_route: assert property (com == 2'b00 |-> pin.out == $past(port_data))
      else $error("port level not routed to pin with output mode zero");

   a_pc_up_clear: assert property (tick && wave == TWC_PHASE && !st_reg.down
                                   && match && st_reg.cnt != `TWC_MAX && com == 2'b10
                                   && quiet |=> !st_reg.oc)
      else $error("up-count match did not clear the output");

   a_pc_down_set: assert property (tick && wave == TWC_PHASE && st_reg.down
                                   && match && st_reg.cnt != 8'h00 && com == 2'b10
                                   && quiet |=> st_reg.oc)
      else $error("down-count match did not set the output");

   a_fast_bottom: assert property (tick && wave == TWC_FAST && st_reg.cnt == `TWC_MAX
                                   && com == 2'b10 && st_reg.cmp_act != `TWC_MAX
                                   && quiet |=> st_reg.oc)
      else $error("fast mode did not set the output at bottom");

   a_toggle_match: assert property (tick && wave == TWC_CTC && match && com == 2'b01
                                    && quiet |=> st_reg.oc != $past(st_reg.oc))
      else $error("toggle mode did not toggle on match");

   a_oe_follow: assert property (pin.oe == $past(port_dir))
      else $error("pin driver does not follow direction bit");

   a_ctc_clear: assert property (tick && wave == TWC_CTC && match && quiet
                                 |=> st_reg.cnt == 8'h00 && compare_flag)
      else $error("clear-on-match mode did not clear on match");

   a_flag_set_wins: assert property (tick && wave == TWC_NORMAL && st_reg.cnt == `TWC_MAX
                                     && wr_flags && !wr_cnt |=> overflow_flag)
      else $error("overflow lost against a clear");

endmodule

/* tb_top.sv */
/*
 * Self-checking testbench for the timer waveform control block.
 * Assumes twc_pkg is compiled first and twc_map.svh sits beside this file.
 */
`timescale 1ns/1ns
`include "twc_map.svh"

module tb_top
   import twc_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals and instance
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   twc_bus_s bus = '0;
   logic [7:0] rdata;
   logic port_data = 1'b0;
   logic port_dir = 1'b0;
   twc_pin_s pin;
   logic overflow_flag;
   logic compare_flag;
   int bad_count = 0;
   int checks_done = 0;

   twc_timer_waveform_control dut (
      .clk(clk),
      .rst_b(rst_b),
      .bus(bus),
      .rdata(rdata),
      .port_data(port_data),
      .port_dir(port_dir),
      .pin(pin),
      .overflow_flag(overflow_flag),
      .compare_flag(compare_flag)
   );

   always #2 clk = ~clk;

   // ---------------------------------------------------------------
   // Bus access and comparison
   // ---------------------------------------------------------------
   function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] c,
                                      input logic [2:0] s);
      return {1'b0, m[0], c, m[1], s};
   endfunction

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] d;
      for (int a = 0; a < 4; a++) begin
         rd(a[1:0], d);
         chk("reset_reg", 16'h0000, {8'h00, d});
      end
   endtask

   task automatic t_force();
      logic [1:0] com[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
      logic lvl[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      logic [7:0] d;
      wr(`TWC_OFF_CTRL, ctl(2'h2, 2'h3, 3'h0));
      wr(`TWC_OFF_COUNT, 8'h40);
      wr(`TWC_OFF_COMPARE, 8'h40);
      for (int i = 0; i < 4; i++) begin
         wr(`TWC_OFF_CTRL, ctl(2'h2, com[i], 3'h0) | 8'h80);
         repeat (3) @(posedge clk);
         #1 chk("force_pin", {15'h0, lvl[i]}, {15'h0, pin.out});
         chk("force_oe", 16'h0001, {15'h0, pin.oe});
      end
      chk("force_flag", 16'h0000, {15'h0, compare_flag});
      rd(`TWC_OFF_CTRL, d);
      chk("force_read", {8'h00, ctl(2'h2, 2'h1, 3'h0)}, {8'h00, d});
      rd(`TWC_OFF_COUNT, d);
      chk("force_count", 16'h0040, {8'h00, d});
   endtask

   task automatic t_port();
      wr(`TWC_OFF_CTRL, ctl(2'h0, 2'h0, 3'h0));
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         port_data <= ~i[0];
         port_dir <= i[0];
         repeat (3) @(posedge clk);
         #1 chk("port_pin", {15'h0, ~i[0]}, {15'h0, pin.out});
         chk("port_oe", {15'h0, i[0]}, {15'h0, pin.oe});
      end
   endtask

   task automatic t_prescale();
      int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
      logic [7:0] a;
      logic [7:0] b;
      for (int s = 0; s < 8; s++) begin
         wr(`TWC_OFF_CTRL, ctl(2'h0, 2'h0, s[2:0]));
         rd(`TWC_OFF_COUNT, a);
         repeat ((s == 0) ? 30 : dv[s] * 4 - 2) @(posedge clk);
         rd(`TWC_OFF_COUNT, b);
         chk("tick_rate", (s == 0) ? 16'h0000 : 16'h0004, {8'h00, b - a});
      end
   endtask

   task automatic t_phase_seq();
      logic [7:0] r[10];
      logic dn;
      logic [7:0] e;
      int tops;
      wr(`TWC_OFF_CTRL, ctl(2'h1, 2'h2, 3'h0));
      wr(`TWC_OFF_COUNT, 8'hfb);
      wr(`TWC_OFF_CTRL, ctl(2'h1, 2'h2, 3'h1));
      @(posedge clk);
      bus <= '{addr: `TWC_OFF_COUNT, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         if (i == 9) begin
            bus.rd <= 1'b0;
         end
         #1 r[i] = rdata;
      end
      dn = 1'b0;
      tops = 0;
      for (int i = 1; i < 10; i++) begin
         if (r[i-1] == `TWC_MAX) begin
            dn = 1'b1;
            tops++;
         end
         e = dn ? r[i-1] - 8'h01 : r[i-1] + 8'h01;
         chk("dual_slope", {8'h00, e}, {8'h00, r[i]});
      end
      chk("top_once", 16'h0001, 16'(tops));
   endtask

   task automatic wait_ovf(output longint t);
      int n = 0;
      #1;
      while (overflow_flag !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1 n++;
      end
      t = $time;
   endtask

   task automatic t_period();
      longint t1;
      longint t2;
      wr(`TWC_OFF_FLAGS, 8'h03);
      wait_ovf(t1);
      wr(`TWC_OFF_FLAGS, 8'h01);
      wait_ovf(t2);
      chk("phase_period", 16'd510, 16'((t2 - t1) / 4));
   endtask

   task automatic t_level(input logic [1:0] com, input logic [7:0] cmp, input int lo,
                          input int hi);
      int h = 0;
      wr(`TWC_OFF_CTRL, ctl(2'h1, com, 3'h1));
      wr(`TWC_OFF_COMPARE, cmp);
      repeat (600) @(posedge clk);
      for (int i = 0; i < 510; i++) begin
         @(posedge clk);
         #1 h += (pin.out === 1'b1);
      end
      chk("pwm_high", 16'h0001, {15'h0, (h >= lo && h <= hi)});
   endtask

   task automatic t_wave(input logic [1:0] m, input logic [1:0] com, input logic [7:0] cmp,
                         input int win, input int hi);
      int h = 0;
      wr(`TWC_OFF_CTRL, ctl(m, com, 3'h1));
      wr(`TWC_OFF_COMPARE, cmp);
      repeat (600) @(posedge clk);
      for (int i = 0; i < win; i++) begin
         @(posedge clk);
         #1 h += (pin.out === 1'b1);
      end
      chk("wave_high", 16'(hi), 16'(h));
   endtask

   task automatic t_flags();
      logic [7:0] d;
      wr(`TWC_OFF_CTRL, ctl(2'h0, 2'h0, 3'h0));
      wr(`TWC_OFF_FLAGS, 8'h03);
      wr(`TWC_OFF_COMPARE, 8'hff);
      wr(`TWC_OFF_COUNT, 8'hfe);
      wr(`TWC_OFF_CTRL, ctl(2'h0, 2'h0, 3'h1));
      wr(`TWC_OFF_FLAGS, 8'h03);
      rd(`TWC_OFF_FLAGS, d);
      chk("set_wins", 16'h0003, {8'h00, d});
      chk("flag_pins", 16'h0003, {14'h0, compare_flag, overflow_flag});
      wr(`TWC_OFF_CTRL, ctl(2'h0, 2'h0, 3'h0));
      wr(`TWC_OFF_FLAGS, 8'h03);
      #1 chk("flag_clear", 16'h0000, {14'h0, compare_flag, overflow_flag});
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      port_dir <= 1'b1;
      t_reset();
      t_force();
      t_port();
      t_prescale();
      t_phase_seq();
      t_period();
      t_level(2'h2, 8'h00, 0, 0);
      t_level(2'h2, 8'hff, 510, 510);
      t_level(2'h3, 8'h00, 510, 510);
      t_level(2'h3, 8'hff, 0, 0);
      t_level(2'h2, 8'h80, 250, 260);
      t_level(2'h3, 8'h80, 250, 260);
      t_wave(2'h3, 2'h2, 8'h40, 256, 65);
      t_wave(2'h3, 2'h3, 8'h40, 256, 191);
      t_wave(2'h2, 2'h1, 8'h09, 200, 100);
      t_flags();
      final_report();
   end

   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      final_report();
   end
endmodule
